// File: design/alsc_bank.sv
// interrupt, sleep and autozero configuration registers of the sensor
// Behaviour
// - status read clears all flags if enabled
// - sleep bit picks state after cycle
// - stop oscillator at enabled interrupt with sleep
// - sleeping looks off but power reads one
// - oscillator resumes once no enabled flag is set
// - autozero interval: zero never, all-ones first
// - autozero interval resets to all ones
// - bit 7 enables saturation interrupt
// - bit 4 enables als threshold interrupt
// - writing one clears a status flag
// - als flag sets at threshold event
// - saturation flag sets at analog saturation
`timescale 1ns/1ps
module alsc_bank
  import alsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic power_on_bit,
  input wire logic cycle_done,
  input wire logic cycle_start,
  input wire logic als_threshold_evt,
  input wire logic saturation_evt,
  input wire logic prox_evt,
  input wire logic prox_irq_en,
  output logic irq_pin,
  output logic osc_enable,
  output logic power_on_readback,
  output logic autozero_run
);
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] az_ff, nxt_az;
  logic [7:0] ien_ff, nxt_ien;
  logic [7:0] stat_ff, nxt_stat;
  logic [7:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;
  logic sleep_ff, nxt_sleep;
  logic osc_ff, nxt_osc;
  logic pwr_ff, nxt_pwr;
  logic az_run;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic irq_cond;

  always_comb begin
    set_bits = 8'h00;
    set_bits[BIT_ALS] = als_threshold_evt;
    set_bits[BIT_SAT] = saturation_evt;
    set_bits[BIT_PROX] = prox_evt;
    clr_bits = 8'h00;
    if (reg_wr && reg_addr == ADDR_STATUS) begin
      clr_bits = reg_wdata;
    end
    if (reg_rd && reg_addr == ADDR_STATUS && cfg_ff[BIT_READ_CLEAR]) begin
      clr_bits = 8'hff;
    end
    // set beats clear so an event in the clearing cycle survives
    nxt_stat = ((stat_ff & ~clr_bits) | set_bits) & STATUS_USED;
  end

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_az = az_ff;
    nxt_ien = ien_ff;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CONFIG_THREE: nxt_cfg = reg_wdata;
        ADDR_AUTOZERO: nxt_az = reg_wdata;
        ADDR_INT_ENABLE: nxt_ien = reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CONFIG_THREE: nxt_rdata = cfg_ff;
        ADDR_AUTOZERO: nxt_rdata = az_ff;
        ADDR_INT_ENABLE: nxt_rdata = ien_ff;
        ADDR_STATUS: nxt_rdata = stat_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_comb begin
    irq_cond = (stat_ff[BIT_ALS] && ien_ff[BIT_ALS])
      || (stat_ff[BIT_SAT] && ien_ff[BIT_SAT])
      || (stat_ff[BIT_PROX] && prox_irq_en);
    nxt_irq = irq_cond;
    nxt_sleep = sleep_ff;
    // sleep is entered only at the end of a measurement cycle
    if (cycle_done && cfg_ff[BIT_SLEEP_AFTER_IRQ] && irq_cond) begin
      nxt_sleep = 1'b1;
    end
    // wake follows the enabled flags, so dropping an enable also wakes;
    // clearing the sleep bit alone does not
    if (!irq_cond) begin
      nxt_sleep = 1'b0;
    end
    nxt_osc = power_on_bit && !nxt_sleep;
    nxt_pwr = power_on_bit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_ff <= CONFIG_THREE_RESET;
      az_ff <= AUTOZERO_RESET;
      ien_ff <= INT_ENABLE_RESET;
      stat_ff <= 8'h00;
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
      sleep_ff <= 1'b0;
      osc_ff <= 1'b0;
      pwr_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      az_ff <= nxt_az;
      ien_ff <= nxt_ien;
      stat_ff <= nxt_stat;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
      sleep_ff <= nxt_sleep;
      osc_ff <= nxt_osc;
      pwr_ff <= nxt_pwr;
    end
  end

  alsc_autozero u_az (
    .clk(clk),
    .rst(rst),
    .interval(az_ff[6:0]),
    .cycle_start(cycle_start && osc_ff),
    .run_az(az_run)
  );

  assign reg_rdata = rdata_ff;
  assign irq_pin = irq_ff;
  assign osc_enable = osc_ff;
  assign power_on_readback = pwr_ff;
  assign autozero_run = az_run;

  a_read_clear: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == ADDR_STATUS && cfg_ff[BIT_READ_CLEAR]
     && set_bits == 8'h00) |=> stat_ff == 8'h00)
    else $error("status not cleared by read");
  a_read_precl: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == ADDR_STATUS) |=> reg_rdata == $past(stat_ff))
    else $error("read data not pre-clear status");
  a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_osc_stop: assert property (@(posedge clk) disable iff (rst)
    sleep_ff |-> !osc_enable)
    else $error("oscillator running while asleep");
  a_sleep_enter: assert property (@(posedge clk) disable iff (rst)
    (cycle_done && cfg_ff[BIT_SLEEP_AFTER_IRQ] && irq_cond)
    |=> sleep_ff)
    else $error("did not sleep after interrupt");
  a_power_read: assert property (@(posedge clk) disable iff (rst)
    (sleep_ff && power_on_bit) |=> power_on_readback)
    else $error("power bit lost while asleep");
  a_az_gate: assert property (@(posedge clk) disable iff (rst)
    !osc_enable |=> !autozero_run)
    else $error("autozero ran with oscillator stopped");
  a_wake_clear: assert property (@(posedge clk) disable iff (rst)
    (sleep_ff && irq_cond) |=> sleep_ff)
    else $error("woke with interrupt pending");
  a_wake_done: assert property (@(posedge clk) disable iff (rst)
    (sleep_ff && !irq_cond) |=> !sleep_ff)
    else $error("still asleep after flags cleared");
  a_als_irq: assert property (@(posedge clk) disable iff (rst)
    (stat_ff[BIT_ALS] && ien_ff[BIT_ALS]) |=> irq_pin)
    else $error("als interrupt missing at pin");
  a_sat_irq: assert property (@(posedge clk) disable iff (rst)
    (stat_ff[BIT_SAT] && ien_ff[BIT_SAT]) |=> irq_pin)
    else $error("saturation interrupt missing at pin");
  a_prox_irq: assert property (@(posedge clk) disable iff (rst)
    (stat_ff[BIT_PROX] && prox_irq_en) |=> irq_pin)
    else $error("proximity interrupt missing at pin");
  a_irq_off: assert property (@(posedge clk) disable iff (rst)
    !irq_cond |=> !irq_pin)
    else $error("interrupt pin high with no enabled flag");
  a_ien_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == ADDR_INT_ENABLE) |=> ien_ff == $past(reg_wdata))
    else $error("interrupt enable write lost");
  a_w1c_flag: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[BIT_ALS]
     && !als_threshold_evt) |=> !stat_ff[BIT_ALS])
    else $error("write one did not clear flag");
  a_als_set: assert property (@(posedge clk) disable iff (rst)
    als_threshold_evt |=> stat_ff[BIT_ALS])
    else $error("als flag not set");
  a_sat_set: assert property (@(posedge clk) disable iff (rst)
    saturation_evt |=> stat_ff[BIT_SAT])
    else $error("saturation flag not set");
  a_az_reset: assert property (@(posedge clk)
    (!rst && $past(rst)) |-> az_ff[6:0] == AZ_FIRST_ONLY)
    else $error("autozero interval reset wrong");
  a_sleep_gate: assert property (@(posedge clk) disable iff (rst)
    (!sleep_ff && !cfg_ff[BIT_SLEEP_AFTER_IRQ]) |=> !sleep_ff)
    else $error("slept with sleep bit clear");

  c_sleep: cover property (@(posedge clk) disable iff (rst)
    !sleep_ff ##1 sleep_ff);
  c_wake: cover property (@(posedge clk) disable iff (rst)
    sleep_ff ##1 !sleep_ff);
  c_rc: cover property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == ADDR_STATUS && cfg_ff[BIT_READ_CLEAR]);
  c_az: cover property (@(posedge clk) disable iff (rst) autozero_run);
  c_sat_irq: cover property (@(posedge clk) disable iff (rst)
    stat_ff[BIT_SAT] && ien_ff[BIT_SAT]);
endmodule // alsc_bank

// File: design/alsc_pkg.sv
// constants for the light sensor interrupt and sleep configuration bank
package alsc_pkg;
  localparam logic [7:0] ADDR_CONFIG_THREE = 8'hab;
  localparam logic [7:0] ADDR_AUTOZERO = 8'hd6;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'hdd;
  localparam logic [7:0] ADDR_STATUS = 8'h93;
  localparam logic [7:0] CONFIG_THREE_RESET = 8'h4c;
  localparam logic [7:0] AUTOZERO_RESET = 8'h7f;
  localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
  localparam int BIT_READ_CLEAR = 7;
  localparam int BIT_SLEEP_AFTER_IRQ = 4;
  localparam int BIT_SAT = 7;
  localparam int BIT_ALS = 4;
  localparam int BIT_PROX = 5;
  localparam logic [6:0] AZ_NEVER = 7'h00;
  localparam logic [6:0] AZ_FIRST_ONLY = 7'h7f;
  localparam logic [7:0] STATUS_USED = 8'hb8;
endpackage

// File: design/alsc_autozero.sv
// autozero scheduler: decides which als cycles get an autozero run
`timescale 1ns/1ps
module alsc_autozero
  import alsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [6:0] interval,
  input wire logic cycle_start,
  output logic run_az
);
  logic [6:0] cnt_ff, nxt_cnt;
  logic first_ff, nxt_first;
  logic run_ff, nxt_run;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_first = first_ff;
    nxt_run = 1'b0;
    if (cycle_start) begin
      nxt_first = 1'b0;
      if (interval == AZ_FIRST_ONLY) begin
        nxt_run = first_ff;
      end else if (interval != AZ_NEVER) begin
        // count from zero so cycle 0, n, 2n... run autozero
        nxt_run = (cnt_ff == 7'h00);
        nxt_cnt = (cnt_ff + 7'h01 >= interval) ? 7'h00 : cnt_ff + 7'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 7'h00;
      first_ff <= 1'b1;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      first_ff <= nxt_first;
      run_ff <= nxt_run;
    end
  end

  assign run_az = run_ff;

  a_az_never: assert property (@(posedge clk) disable iff (rst)
    (cycle_start && interval == AZ_NEVER) |=> !run_az)
    else $error("autozero ran with interval zero");
  a_az_first: assert property (@(posedge clk) disable iff (rst)
    (cycle_start && interval == AZ_FIRST_ONLY && !first_ff) |=> !run_az)
    else $error("autozero repeated in first-only mode");
endmodule // alsc_autozero

// File: test/alsc_host.sv
// host model that reads and writes the sensor registers
`timescale 1ns/1ps
module alsc_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // data is scrambled after the strobe so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule // alsc_host

// File: test/alsc_bank_tb.sv
// self-checking bench for the interrupt and sleep configuration bank
`timescale 1ns/1ps
module alsc_bank_tb;
  import alsc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pwr_on = 1'b1;
  logic c_done = 1'b0;
  logic c_start = 1'b0;
  logic als_e = 1'b0;
  logic sat_e = 1'b0;
  logic prox_e = 1'b0;
  logic prox_en = 1'b0;
  logic wr, rd, irq, osc, pwr_rb, az;
  logic [7:0] addr, wdata, rdata, v;
  int fail_count = 0;
  int total_checks = 0;
  always #25 clk = ~clk;
  alsc_host u_alsc_host (.clk(clk), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
  alsc_bank u_alsc_bank (.clk(clk), .rst(rst), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .power_on_bit(pwr_on), .cycle_done(c_done), .cycle_start(c_start),
    .als_threshold_evt(als_e), .saturation_evt(sat_e), .prox_evt(prox_e),
    .prox_irq_en(prox_en), .irq_pin(irq), .osc_enable(osc),
    .power_on_readback(pwr_rb), .autozero_run(az));
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // sel is one-hot: cycle done, prox, als, saturation
  task automatic strobe(input logic [3:0] sel);
    @(negedge clk);
    {c_done, prox_e, als_e, sat_e} = sel;
    @(negedge clk);
    {c_done, prox_e, als_e, sat_e} = 4'h0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rs(logic [7:0] e);
    u_alsc_host.rd(ADDR_STATUS, v);
    chk("status", v, e);
  endtask
  task automatic az_run(logic [7:0] n, logic [7:0] runs);
    logic [7:0] seen;
    seen = 8'h00;
    u_alsc_host.wr(ADDR_AUTOZERO, n);
    repeat (3) begin
      @(negedge clk);
      c_start = 1'b1;
      @(negedge clk);
      c_start = 1'b0;
      // the run flag stands one cycle only, so look at it here
      seen = seen + {7'h00, az};
      @(negedge clk);
    end
    chk("autozero runs", seen, runs);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    u_alsc_host.rd(ADDR_CONFIG_THREE, v);
    chk("config_three", v, 8'h4c);
    u_alsc_host.rd(ADDR_AUTOZERO, v);
    chk("autozero_config", v, 8'h7f);
    u_alsc_host.rd(ADDR_INT_ENABLE, v);
    chk("interrupt_enable", v, 8'h00);
    u_alsc_host.rd(8'h10, v);
    chk("unmapped", v, 8'h00);
    $display("test defaults done");
    az_run(8'h7f, 8'h01);
    az_run(8'h00, 8'h00);
    az_run(8'h01, 8'h03);
    $display("test autozero done");
    u_alsc_host.wr(ADDR_INT_ENABLE, 8'h10);
    strobe(4'h1);
    chk("masked saturation irq", {7'h00, irq}, 8'h00);
    rs(8'h80);
    u_alsc_host.wr(ADDR_STATUS, 8'h80);
    rs(8'h00);
    strobe(4'h2);
    chk("als irq", {7'h00, irq}, 8'h01);
    rs(8'h10);
    u_alsc_host.wr(ADDR_STATUS, 8'h10);
    repeat (2) @(negedge clk);
    chk("als irq cleared", {7'h00, irq}, 8'h00);
    u_alsc_host.wr(ADDR_INT_ENABLE, 8'h80);
    strobe(4'h1);
    chk("saturation irq", {7'h00, irq}, 8'h01);
    u_alsc_host.wr(ADDR_STATUS, 8'h80);
    $display("test interrupts done");
    u_alsc_host.wr(ADDR_CONFIG_THREE, 8'hcc);
    strobe(4'h2);
    rs(8'h10);
    rs(8'h00);
    $display("test read clear done");
    u_alsc_host.wr(ADDR_CONFIG_THREE, 8'h4c);
    prox_en = 1'b1;
    strobe(4'h4);
    strobe(4'h8);
    chk("awake without sleep bit", {7'h00, osc}, 8'h01);
    u_alsc_host.wr(ADDR_CONFIG_THREE, 8'h5c);
    strobe(4'h8);
    chk("asleep", {7'h00, osc}, 8'h00);
    chk("power readback", {7'h00, pwr_rb}, 8'h01);
    u_alsc_host.wr(ADDR_STATUS, 8'h20);
    repeat (2) @(negedge clk);
    chk("woken", {7'h00, osc}, 8'h01);
    $display("test sleep done");
    @(negedge clk);
    pwr_on = 1'b0;
    repeat (2) @(negedge clk);
    chk("powered off", {7'h00, osc}, 8'h00);
    chk("power readback off", {7'h00, pwr_rb}, 8'h00);
    az_run(8'h01, 8'h00);
    $display("test power off done");
    end_sim();
  end
endmodule // alsc_bank_tb
